//--- common/power_seq_pkg.sv
// power_seq_pkg: phases, pin-drive codes, timing constants and carrier structs
// assumes a 125 MHz system clock; times are in milliseconds unless named otherwise
package power_seq_pkg;
  // clock rate
  localparam int unsigned CLK_HZ = 125_000_000;
  // slow reference tick period in microseconds
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;
  // phase boundaries measured from ignition, in ms
  localparam int unsigned RESET_END_MS = 100;
  localparam int unsigned HW_END_MS = 5000;
  localparam int unsigned FW_END_MS = 32000;
  // pcie activity bursts, in ms, and burst length
  localparam int unsigned PCIE_BURST1_MS = 11000;
  localparam int unsigned PCIE_BURST2_MS = 13000;
  localparam int unsigned PCIE_BURST_LEN_MS = 10;
  // carrier-detect pulse during hardware init: up window
  localparam int unsigned CD_UP_START_MS = 1000;
  localparam int unsigned CD_UP_END_MS = 2000;
  // serial lines switch pull-down to pull-up at this point of hardware init
  localparam int unsigned SER_PU_MS = 1000;
  // serial lines release to high impedance at this point of firmware init
  localparam int unsigned SER_TRI_MS = 6000;
  // sim clock starts at this point of firmware init
  localparam int unsigned SIM_CLK_MS = 6000;
  // sim clock half-period in system cycles
  localparam int unsigned SIM_HALF_CYCLES = 16;
  // width of the millisecond counter
  localparam int unsigned MS_W = 16;

  // power phases
  typedef enum logic [2:0] {
    PH_OFF, PH_RESET, PH_HW_INIT, PH_FW_INIT, PH_ACTIVE
  } phase_type;

  // drive code of a pin
  typedef enum logic [2:0] {
    DRV_TRI, DRV_PD, DRV_PU, DRV_LOW, DRV_HIGH, DRV_CLK, DRV_ACT
  } drive_type;

  // drive state of the managed pin groups
  typedef struct packed {
    drive_type serial;     // both serial port data and handshake lines
    drive_type carrier;    // carrier detect output
    drive_type sim_clk;    // first sim clock
    drive_type emerg;      // emergency shutdown input bias
    drive_type pcie;       // pcie lanes
  } pin_state_type;

  // ready notice request toward the command ports
  typedef struct packed {
    logic normal;          // ready_notice_normal
    logic airplane;        // ready_notice_airplane
  } notice_type;
endpackage : power_seq_pkg

//--- src/sim_clock_gen.sv
// sim_clock_gen: free-running divided clock for the first sim card, gated by enable
// assumes a single system clock; output is a flip-flop
`timescale 1ns/1ps
module sim_clock_gen
  import power_seq_pkg::*;
#(
  parameter int unsigned HALF = SIM_HALF_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic en_i,
  output logic clk_o
);
  // half-period counter
  logic [7:0] cnt_reg;
  logic wrap;
  assign wrap = (cnt_reg == 8'(HALF - 1));

  // count and toggle while enabled, otherwise sit low
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_reg <= 8'h00;
      clk_o <= 1'b0;
    end else if (!en_i) begin
      cnt_reg <= 8'h00;
      clk_o <= 1'b0;
    end else if (wrap) begin
      cnt_reg <= 8'h00;
      clk_o <= ~clk_o;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
endmodule : sim_clock_gen

//--- src/module_power_on_sequencer.sv
// module_power_on_sequencer: steps a cellular module from power-down to active
// assumes inputs synchronous to sys_clk_i; the ignition line is open drain, idle high
// Notes on behaviour
// - ignition low in power-down starts power-on
// - out-of-limit supply or temperature forces off
// - ready notice on the plain ports within 32 s
// - notice says normal or airplane mode
// - usb notice needs configured and optional host-ready
// - phases reset, hw init, fw init, active
// - signals defined in init and after startup
// - command-configured interface changes pin states again
// - serial lines tri, pd-pu, pu-tri, tri
// - carrier detect pd, pd-pu-pd, then pd
// - sim clock pd, runs in fw init, low
// - emergency shutdown biased, then pulled up
// - two pcie bursts near 11 s, 13 s
// - shutdown command returns to power-down
`timescale 1ns/1ps
module module_power_on_sequencer
  import power_seq_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES,  // cycles per ms tick
  parameter int unsigned NPORTS = 3               // command ports; last one is usb
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic ignition_line_i,        // active low start request
  input wire logic limits_ok_i,            // supply and temperature inside limits
  input wire logic airplane_mode_i,        // startup mode selection
  input wire logic usb_configured_i,       // usb interface configured
  input wire logic expect_host_ready_option_i,
  input wire logic usb_host_ready_i,       // usb host signalled ready to receive
  input wire logic shutdown_command_i,     // one-cycle pulse
  input wire logic iface_config_i,         // interface configured by command
  input wire logic [2:0] iface_drive_i,    // drive code applied on configure
  output logic powered_o,
  output phase_type phase_o,
  output pin_state_type pins_o,
  output logic sim_one_clock_o,
  output notice_type notice_o,             // kind of pending notice
  output logic [NPORTS-1:0] notice_port_o  // one-cycle notice strobe per port
);
  // ignition synchroniser and edge detector
  logic ign_s1_reg;
  logic ign_s2_reg;
  logic ign_d_reg;
  logic ign_fall;
  // millisecond tick divider
  logic [31:0] div_reg;
  logic tick;
  // time since ignition in ms
  logic [MS_W-1:0] ms_reg;
  phase_type phase_reg;
  phase_type phase_next;
  // ready notice pending per port
  logic [NPORTS-1:0] pend_reg;
  logic [NPORTS-1:0] send;
  logic usb_ok;
  logic mode_air_reg;
  // command override of serial lines after startup
  logic ovr_reg;
  drive_type ovr_drv_reg;
  logic sim_clk;
  logic sim_en;
  pin_state_type pins_next;

  assign ign_fall = ign_d_reg & ~ign_s2_reg;
  assign tick = (div_reg == 32'(TICK_DIV - 1));

  // synchronise ignition; first stage feeds only the second
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ign_s1_reg <= 1'b1;
      ign_s2_reg <= 1'b1;
      ign_d_reg <= 1'b1;
    end else begin
      ign_s1_reg <= ignition_line_i;
      ign_s2_reg <= ign_s1_reg;
      ign_d_reg <= ign_s2_reg;
    end
  end

  // slow reference tick, restarted at the ignition edge
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_reg <= 32'h0;
    end else if (phase_reg == PH_OFF || tick) begin
      div_reg <= 32'h0;
    end else begin
      div_reg <= div_reg + 32'h1;
    end
  end

  // elapsed time, frozen once active
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ms_reg <= '0;
    end else if (phase_reg == PH_OFF) begin
      ms_reg <= '0;
    end else if (tick && phase_reg != PH_ACTIVE) begin
      ms_reg <= ms_reg + 1'b1;
    end
  end

  // phase transitions
  always_comb begin
    phase_next = phase_reg;
    unique case (phase_reg)
      PH_OFF: if (ign_fall) phase_next = PH_RESET;
      PH_RESET: if (ms_reg >= MS_W'(RESET_END_MS)) phase_next = PH_HW_INIT;
      PH_HW_INIT: if (ms_reg >= MS_W'(HW_END_MS)) phase_next = PH_FW_INIT;
      PH_FW_INIT: if (ms_reg >= MS_W'(FW_END_MS)) phase_next = PH_ACTIVE;
      PH_ACTIVE: phase_next = PH_ACTIVE;
    endcase
    // limits or shutdown command force power-down
    if (phase_reg != PH_OFF && (!limits_ok_i || shutdown_command_i)) begin
      phase_next = PH_OFF;
    end
  end

  // phase register
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      phase_reg <= PH_OFF;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // usb port gating
  assign usb_ok = usb_configured_i & (~expect_host_ready_option_i | usb_host_ready_i);
  assign send[NPORTS-2:0] = pend_reg[NPORTS-2:0];
  assign send[NPORTS-1] = pend_reg[NPORTS-1] & usb_ok;

  // pending notices armed on entering active, cleared when sent
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pend_reg <= '0;
      mode_air_reg <= 1'b0;
    end else if (phase_next == PH_OFF) begin
      pend_reg <= '0;
    end else if (phase_reg == PH_FW_INIT && phase_next == PH_ACTIVE) begin
      pend_reg <= '1;
      mode_air_reg <= airplane_mode_i;
    end else begin
      pend_reg <= pend_reg & ~send;
    end
  end

  // command reconfiguration after startup
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ovr_reg <= 1'b0;
      ovr_drv_reg <= DRV_TRI;
    end else if (phase_reg != PH_ACTIVE) begin
      ovr_reg <= 1'b0;
    end else if (iface_config_i) begin
      ovr_reg <= 1'b1;
      ovr_drv_reg <= drive_type'(iface_drive_i);
    end
  end

  // per-phase pin selection
  always_comb begin
    pins_next = '{serial: DRV_TRI, carrier: DRV_PD, sim_clk: DRV_PD,
                  emerg: DRV_PU, pcie: DRV_TRI};
    unique case (phase_reg)
      PH_OFF: pins_next.carrier = DRV_TRI;
      PH_RESET: pins_next.emerg = DRV_PD;
      PH_HW_INIT: begin
        pins_next.serial = (ms_reg < MS_W'(SER_PU_MS)) ? DRV_PD : DRV_PU;
        if (ms_reg >= MS_W'(CD_UP_START_MS) && ms_reg < MS_W'(CD_UP_END_MS)) begin
          pins_next.carrier = DRV_PU;
        end
      end
      PH_FW_INIT: begin
        pins_next.serial = (ms_reg < MS_W'(SER_TRI_MS)) ? DRV_PU : DRV_TRI;
        if (ms_reg >= MS_W'(SIM_CLK_MS)) pins_next.sim_clk = DRV_CLK;
        if ((ms_reg >= MS_W'(PCIE_BURST1_MS) &&
             ms_reg < MS_W'(PCIE_BURST1_MS + PCIE_BURST_LEN_MS)) ||
            (ms_reg >= MS_W'(PCIE_BURST2_MS) &&
             ms_reg < MS_W'(PCIE_BURST2_MS + PCIE_BURST_LEN_MS))) begin
          pins_next.pcie = DRV_ACT;
        end
      end
      PH_ACTIVE: begin
        pins_next.sim_clk = DRV_LOW;
        if (ovr_reg) pins_next.serial = ovr_drv_reg;
      end
    endcase
  end

  assign sim_en = (phase_reg == PH_FW_INIT) && (ms_reg >= MS_W'(SIM_CLK_MS));

  // divided sim clock
  sim_clock_gen #(
    .HALF(SIM_HALF_CYCLES)
  ) u_sim_clk (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .en_i(sim_en),
    .clk_o(sim_clk)
  );

  // registered outputs
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      powered_o <= 1'b0;
      phase_o <= PH_OFF;
      pins_o <= '{serial: DRV_TRI, carrier: DRV_TRI, sim_clk: DRV_PD,
                  emerg: DRV_PU, pcie: DRV_TRI};
      sim_one_clock_o <= 1'b0;
      notice_o <= '0;
      notice_port_o <= '0;
    end else begin
      powered_o <= (phase_reg != PH_OFF);
      phase_o <= phase_reg;
      pins_o <= pins_next;
      sim_one_clock_o <= sim_clk;
      notice_o <= '{normal: ~mode_air_reg, airplane: mode_air_reg};
      notice_port_o <= send;
    end
  end

  // helper: cycles spent in active with a notice still pending on the first plain port
  logic [3:0] wait_cnt;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wait_cnt <= 4'h0;
    end else if (pend_reg[0] && wait_cnt != 4'hF) begin
      wait_cnt <= wait_cnt + 4'h1;
    end else if (!pend_reg[0]) begin
      wait_cnt <= 4'h0;
    end
  end

  sequence s_ign_edge;
    phase_reg == PH_OFF && ign_fall;
  endsequence
  // an ignition edge in power-down starts the module even with limits out or shutdown set; checked only when neither is present
  property p_start;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      s_ign_edge and (limits_ok_i && !shutdown_command_i) |=> phase_reg == PH_RESET;
  endproperty
  a_start: assert property (p_start) else $error("no start on ignition edge");
  property p_limits;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      phase_reg != PH_OFF && !limits_ok_i |=> phase_reg == PH_OFF ##1 !powered_o;
  endproperty
  a_limits: assert property (p_limits) else $error("no switch off on limits");
  property p_notice;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      phase_reg == PH_FW_INIT && phase_next == PH_ACTIVE |=> ##1 notice_port_o[0];
  endproperty
  a_notice: assert property (p_notice) else $error("ready notice missing");
  property p_kind;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      notice_port_o != '0 |-> notice_o.normal != notice_o.airplane;
  endproperty
  a_kind: assert property (p_kind) else $error("notice kind ambiguous");
  // the usb strobe on the pin must follow a cycle in which the usb gating inputs allowed it
  property p_usb;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      notice_port_o[NPORTS-1] |-> $past(usb_configured_i) &&
        (!$past(expect_host_ready_option_i) || $past(usb_host_ready_i));
  endproperty
  a_usb: assert property (p_usb) else $error("usb notice sent early");
  property p_order;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      phase_reg != $past(phase_reg) && phase_reg != PH_OFF |->
        phase_reg == $past(phase_reg) + 3'd1;
  endproperty
  a_order: assert property (p_order) else $error("phase skipped");
  property p_serial_act;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      phase_reg == PH_ACTIVE && !ovr_reg |=> pins_o.serial == DRV_TRI;
  endproperty
  a_serial_act: assert property (p_serial_act) else $error("serial not released");
  property p_emerg;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      phase_reg inside {PH_HW_INIT, PH_FW_INIT, PH_ACTIVE} |=> pins_o.emerg == DRV_PU;
  endproperty
  a_emerg: assert property (p_emerg) else $error("emergency line not pulled up");
  property p_sim_low;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      phase_reg == PH_ACTIVE |=> pins_o.sim_clk == DRV_LOW ##1 !sim_one_clock_o;
  endproperty
  a_sim_low: assert property (p_sim_low) else $error("sim clock not low");
  // lane activity on the pins only in firmware init, and not before the first burst time
  property p_pcie;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      pins_o.pcie == DRV_ACT |-> phase_o == PH_FW_INIT &&
        $past(ms_reg) >= MS_W'(PCIE_BURST1_MS);
  endproperty
  a_pcie: assert property (p_pcie) else $error("pcie burst outside fw init");
  property p_drain;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      wait_cnt < 4'h3;
  endproperty
  a_drain: assert property (p_drain) else $error("plain port notice stuck");
endmodule : module_power_on_sequencer

//--- tb/host_app_model.sv
// host_app_model: host side that pulls ignition and sends a command after the ready notice
// assumes the bench adds the pull-up on the ignition line
`timescale 1ns/1ps
module host_app_model #(
  parameter int unsigned HOLD = 300  // cycles of ignition held low
) (
  input wire logic sys_clk_i,
  input wire logic go_i,           // start request from the bench
  input wire logic notice_i,       // ready strobe of the first port
  input wire logic [2:0] code_i,   // drive code to configure
  output logic pull_low_o,         // open-drain pull, never drives high
  output logic cfg_o,              // one-cycle configure command
  output logic [2:0] drive_o
);
  int hold_cnt = 0;  // ignition cycles left
  int wait_cnt = 0;  // delay after the notice
  initial begin
    pull_low_o = 1'b0;
    cfg_o = 1'b0;
    drive_o = 3'h0;
  end
  // ignition pulse: only a pull to ground, released after the hold time
  always @(negedge sys_clk_i) begin
    if (go_i && hold_cnt == 0) begin
      pull_low_o <= 1'b1;
      hold_cnt <= HOLD;
    end else if (hold_cnt > 1) begin
      hold_cnt <= hold_cnt - 1;
    end else if (hold_cnt == 1) begin
      pull_low_o <= 1'b0;
      hold_cnt <= 0;
    end
  end
  // first command only once the device has announced itself
  always @(negedge sys_clk_i) begin
    cfg_o <= (wait_cnt == 1);
    drive_o <= (wait_cnt == 1) ? code_i : ~code_i;
    if (notice_i) begin
      wait_cnt <= 8;
    end else if (wait_cnt > 0) begin
      wait_cnt <= wait_cnt - 1;
    end
  end
endmodule : host_app_model

//--- tb/module_power_on_sequencer_bench.sv
// module_power_on_sequencer_bench: self-checking bench with a phase and pin model
// assumes a 1 ms tick shortened to TD cycles; inputs change at the falling edge
`timescale 1ns/1ps
module module_power_on_sequencer_bench;
  import power_seq_pkg::*;
  localparam int TD = 1;  // cycles per ms tick
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic limits_ok = 1'b1;
  logic airplane = 1'b0;
  logic usb_cfg = 1'b0;
  logic opt = 1'b0;
  logic host_rdy = 1'b0;
  logic shut = 1'b0;
  logic go = 1'b0;
  logic pull_low;
  logic cfg;
  logic [2:0] drive;
  logic [2:0] code = 3'h0;
  logic powered;
  phase_type phase;
  pin_state_type pins;
  logic sim_clk;
  notice_type kind;
  logic [2:0] strobe;
  wire ign = pull_low ? 1'b0 : 1'b1;  // pull-up on the open-drain line
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;
  int t0 = 0;
  int cnt[3] = '{0, 0, 0};  // notices seen per port
  notice_type last[3];  // kind seen with each notice
  logic [31:0] seed = 32'hEEBB;
  int cp[10] = '{50, 500, 1500, 3000, 5500, 7000, 11005, 12000, 13005, 20000};
  always #4 sys_clk_i = ~sys_clk_i;
  // cycle count and notice monitor
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 3; i++) begin
      if (strobe[i] === 1'b1) begin
        cnt[i] <= cnt[i] + 1;
        last[i] <= kind;
      end
    end
  end
  module_power_on_sequencer #(.TICK_DIV(TD), .NPORTS(3)) u_module_power_on_sequencer (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .ignition_line_i(ign),
    .limits_ok_i(limits_ok), .airplane_mode_i(airplane), .usb_configured_i(usb_cfg),
    .expect_host_ready_option_i(opt), .usb_host_ready_i(host_rdy),
    .shutdown_command_i(shut), .iface_config_i(cfg), .iface_drive_i(drive),
    .powered_o(powered), .phase_o(phase), .pins_o(pins), .sim_one_clock_o(sim_clk),
    .notice_o(kind), .notice_port_o(strobe));
  host_app_model #(.HOLD(150 * TD)) u_host_app_model (
    .sys_clk_i(sys_clk_i), .go_i(go), .notice_i(strobe[0]), .code_i(code),
    .pull_low_o(pull_low), .cfg_o(cfg), .drive_o(drive));
  // xorshift source of random stimulus
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // expected phase and pin drive at a time after ignition
  function automatic pin_state_type model_pins(int ms, output phase_type ph);
    pin_state_type p;
    p = '{DRV_TRI, DRV_PD, DRV_PD, DRV_PU, DRV_TRI};
    if (ms < RESET_END_MS) begin
      ph = PH_RESET;
      p.emerg = DRV_PD;
    end else if (ms < HW_END_MS) begin
      ph = PH_HW_INIT;
      p.serial = (ms < SER_PU_MS) ? DRV_PD : DRV_PU;
      if (ms >= CD_UP_START_MS && ms < CD_UP_END_MS) p.carrier = DRV_PU;
    end else if (ms < FW_END_MS) begin
      ph = PH_FW_INIT;
      p.serial = (ms < SER_TRI_MS) ? DRV_PU : DRV_TRI;
      if (ms >= SIM_CLK_MS) p.sim_clk = DRV_CLK;
      if (ms >= PCIE_BURST1_MS && ms < PCIE_BURST1_MS + PCIE_BURST_LEN_MS) p.pcie = DRV_ACT;
      if (ms >= PCIE_BURST2_MS && ms < PCIE_BURST2_MS + PCIE_BURST_LEN_MS) p.pcie = DRV_ACT;
    end else begin
      ph = PH_ACTIVE;
      p.sim_clk = DRV_LOW;
    end
    return p;
  endfunction : model_pins
  // one comparison, reported at once on mismatch
  task chk(input bit ok, input string msg);
    samples_checked++;
    if (!ok) begin
      $display("ERROR at %0t: %s", $time, msg);
      fails++;
    end
  endtask : chk
  // ask the host to pull ignition; times count from here
  task start();
    go <= 1'b1;
    t0 = cyc;
    @(negedge sys_clk_i);
    go <= 1'b0;
  endtask : start
  task at_ms(input int ms);
    while (cyc < t0 + ms * TD) @(negedge sys_clk_i);
  endtask : at_ms
  task test_done();
    $display("checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done
  // watchdog sized from two full power-ups plus the short runs
  initial begin
    #(90000 * 8);
    fails++;
    test_done();
  end
  // main sequence
  initial begin
    pin_state_type ep;
    phase_type eph;
    int tg;
    logic prev_clk;
    repeat (12) @(negedge sys_clk_i);
    rstn_i <= 1'b1;
    @(negedge sys_clk_i);
    airplane <= 1'(rnd());
    code <= 3'(rnd() % 7);
    start();
    foreach (cp[i]) begin
      at_ms(cp[i]);
      ep = model_pins(cp[i], eph);
      chk(phase === eph && powered === 1'b1, "phase");
      chk(pins === ep, "pin drive");
      tg = 0;
      prev_clk = sim_clk;
      for (int k = 0; k < 100; k++) begin
        @(negedge sys_clk_i);
        if (sim_clk !== prev_clk) tg++;
        prev_clk = sim_clk;
      end
      chk((ep.sim_clk == DRV_CLK) ? (tg >= 100 / SIM_HALF_CYCLES - 1) : (tg == 0), "sim clk");
    end
    $display("test power-up phases done");
    at_ms(32100);
    ep = model_pins(32100, eph);
    chk(phase === eph && pins.sim_clk === DRV_LOW, "active");
    chk(cnt[0] == 1 && cnt[1] == 1 && cnt[2] == 0, "notice count");
    chk(last[0] === {~airplane, airplane} && last[1] === last[0], "notice kind");
    chk(pins.serial === drive_type'(code), "configured serial drive");
    usb_cfg <= 1'b1;
    opt <= 1'b1;
    repeat (50) @(negedge sys_clk_i);
    chk(cnt[2] == 0, "usb waits for host");
    host_rdy <= 1'b1;
    repeat (20) @(negedge sys_clk_i);
    chk(cnt[2] == 1 && last[2] === {~airplane, airplane}, "usb notice");
    $display("test notices done");
    start();
    repeat (20) @(negedge sys_clk_i);
    chk(phase === PH_ACTIVE, "ignition refused when on");
    at_ms(200);
    shut <= 1'b1;
    @(negedge sys_clk_i);
    shut <= 1'b0;
    repeat (3) @(negedge sys_clk_i);
    chk(powered === 1'b0 && phase === PH_OFF, "shutdown");
    airplane <= ~airplane;
    start();
    at_ms(200);
    chk(phase === PH_HW_INIT, "restart");
    at_ms(32100);
    chk(phase === PH_ACTIVE && cnt[0] == 2 && cnt[2] == 2, "second notice count");
    chk(last[0] === {~airplane, airplane} && last[1] === last[0], "second kind");
    limits_ok <= 1'b0;
    repeat (3) @(negedge sys_clk_i);
    chk(powered === 1'b0 && phase === PH_OFF, "limits off when active");
    limits_ok <= 1'b1;
    start();
    at_ms(200);
    chk(phase === PH_HW_INIT, "restart after limits");
    limits_ok <= 1'b0;
    repeat (3) @(negedge sys_clk_i);
    chk(powered === 1'b0 && phase === PH_OFF, "limits off");
    limits_ok <= 1'b1;
    $display("test shutdown paths done");
    test_done();
  end
endmodule : module_power_on_sequencer_bench
